// [rtl/spm_pkg.sv]
// Package for the serial port with modem lines: register map, field
// positions, reset values, bit-rate limits, frame limits and state codes.
// Assumes a 200 MHz system clock and a classic Wishbone register bus.
package spm_pkg;

    // Clock and bit-rate limits, in bit/s
    localparam int CLK_HZ       = 200_000_000;
    localparam int BAUD_LOWEST  = 300;
    localparam int BAUD_232_MAX = 115_200;
    localparam int BAUD_485_MAX = 250_000;
    localparam int BAUD_DEFAULT = 9_600;

    // Clock cycles per bit; a highest rate rounds the divisor up
    localparam int DIV_W = 20;
    localparam logic [DIV_W-1:0] DIV_MAX     = DIV_W'(CLK_HZ / BAUD_LOWEST);
    localparam logic [DIV_W-1:0] DIV_MIN_232 = DIV_W'((CLK_HZ + BAUD_232_MAX - 1) / BAUD_232_MAX);
    localparam logic [DIV_W-1:0] DIV_MIN_485 = DIV_W'((CLK_HZ + BAUD_485_MAX - 1) / BAUD_485_MAX);
    localparam logic [DIV_W-1:0] DIV_RESET   = DIV_W'(CLK_HZ / BAUD_DEFAULT);

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_BAUD   = 8'h04;
    localparam logic [7:0] ADDR_TXDATA = 8'h08;
    localparam logic [7:0] ADDR_RXDATA = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_FRAME  = 8'h14;

    // Control register fields
    localparam int CTRL_W      = 9;
    localparam int C_READY     = 0;
    localparam int C_LINK485   = 1;
    localparam int C_PERF      = 2;
    localparam int C_PAR_EN    = 3;
    localparam int C_PAR_ODD   = 4;
    localparam int C_PROTO_LO  = 5;
    localparam int C_PROTO_HI  = 6;
    localparam int C_TWO_STOP  = 7;
    localparam int C_FLOW      = 8;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

    // Framing protocol codes
    localparam logic [1:0] PROTO_FREE   = 2'h0;
    localparam logic [1:0] PROTO_BLOCK  = 2'h1;
    localparam logic [1:0] PROTO_MB_MST = 2'h2;
    localparam logic [1:0] PROTO_MB_SLV = 2'h3;

    // Sticky status flags, status bits 8 upward
    localparam int S_FRAME_ERR = 0;
    localparam int S_PAR_ERR   = 1;
    localparam int S_OVERRUN   = 2;
    localparam int S_TX_LIMIT  = 3;
    localparam int S_RX_LIMIT  = 4;
    localparam int S_RX_END    = 5;
    localparam int FLAG_W      = 6;

    // Frame length limits in bytes, and idle gaps that close a frame
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] FRAME_MAX_NORM    = 12'h800;
    localparam logic [CNT_W-1:0] FRAME_MAX_PERF_RX = 12'h018;
    localparam logic [CNT_W-1:0] FRAME_MAX_PERF_TX = 12'h01e;
    localparam logic [5:0]       GAP_BITS_FREE     = 6'h14;
    localparam logic [5:0]       GAP_BITS_MODBUS   = 6'h23;

    localparam int DATA_BITS = 8;
    localparam int FIFO_DEPTH = 4;

    // Character engine states
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_START = 5'b00010,
        ST_DATA  = 5'b00100,
        ST_PAR   = 5'b01000,
        ST_STOP  = 5'b10000
    } spm_state_t;

endpackage : spm_pkg

// [rtl/spm_serial_port.sv]
// Serial port with modem lines: transmit FIFO, character transmitter and
// receiver, modem handshake lines and a classic Wishbone register slave.
// Assumes one 200 MHz clock, synchronous reset and asynchronous pins.
//
// Function
// - Transmit line held at one when idle
// - Request-to-send raised while data waits and the ready bit is set
// - No transmission while request-to-send is low
// - Data-terminal-ready shows device ready
// - Bit rate configurable from 300 to 250000
// - RS232 link limited to 115.2 kbps
// - 250 kbit/s allowed only on RS485
// - Frame limits: 2 kbyte, or 24/30
// - Selectable RS232 or RS422/485 link
// - Free, block and Modbus master/slave modes
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps

// Small FIFO in flip-flops, valid and ready on both sides
module spm_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0]   FULL_CNT = (AW+1)'(D);
    localparam logic [AW-1:0] LAST_IX  = AW'(D - 1);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_ix;
    logic [AW-1:0] rd_ix;
    logic [AW:0]   count;
    wire           push = in_valid_i && in_ready_o;
    wire           pop  = out_valid_o && out_ready_i;
    assign in_ready_o  = (count != FULL_CNT);
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ix];
    // Pointers and occupancy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ix <= '0;
            rd_ix <= '0;
            count <= '0;
        end else begin
            if (push) wr_ix <= (wr_ix == LAST_IX) ? '0 : wr_ix + 1'b1;
            if (pop)  rd_ix <= (rd_ix == LAST_IX) ? '0 : rd_ix + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    // Storage write
    always_ff @(posedge clk_i) begin
        if (push) mem[wr_ix] <= in_data_i;
    end
endmodule : spm_fifo

module spm_serial_port
    import spm_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rxd_i,
    input  wire logic        cts_i,
    input  wire logic        dsr_i,
    input  wire logic        dcd_i,
    input  wire logic        ri_i,
    output logic             txd_o,
    output logic             rts_o,
    output logic             dtr_o,
    output logic             link_485_o,
    output logic             drv_en_o
);
    // Pin synchronisers and agreement filter
    logic [4:0] pin_s1, pin_s2, pin_s3, pin_f;
    wire  [4:0] pins = {ri_i, dcd_i, dsr_i, cts_i, rxd_i};
    wire        rx_f  = pin_f[0];
    wire        cts_f = pin_f[1];
    // Three stages; a level counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1 <= 5'h01;
            pin_s2 <= 5'h01;
            pin_s3 <= 5'h01;
            pin_f  <= 5'h01;
        end else begin
            pin_s1 <= pins;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_f  <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
        end
    end
    // Register storage and address decode
    logic [CTRL_W-1:0] ctrl;
    logic [DIV_W-1:0]  baud;
    logic [FLAG_W-1:0] flags;
    logic [7:0]        rx_byte;
    logic              rx_valid;
    logic [CNT_W-1:0]  tx_cnt, rx_cnt;
    wire req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire hit_ctrl = (wb_adr_i == ADDR_CTRL);
    wire hit_baud = (wb_adr_i == ADDR_BAUD);
    wire hit_tx   = (wb_adr_i == ADDR_TXDATA);
    wire hit_rx   = (wb_adr_i == ADDR_RXDATA);
    wire hit_stat = (wb_adr_i == ADDR_STATUS);
    wire hit_frm  = (wb_adr_i == ADDR_FRAME);
    wire       link485  = ctrl[C_LINK485];
    wire [1:0] proto    = ctrl[C_PROTO_HI:C_PROTO_LO];
    wire       modbus   = (proto == PROTO_MB_MST) || (proto == PROTO_MB_SLV);
    wire [5:0] gap_bits = modbus ? GAP_BITS_MODBUS : GAP_BITS_FREE;
    // Bit-rate clamp per link
    wire [DIV_W-1:0] div_min = link485 ? DIV_MIN_485 : DIV_MIN_232;
    wire [DIV_W-1:0] div_eff = (baud < div_min) ? div_min :
                               (baud > DIV_MAX) ? DIV_MAX : baud;
    wire [DIV_W-1:0] div_top  = div_eff - 1'b1;
    wire [DIV_W-1:0] div_half = {1'b0, div_eff[DIV_W-1:1]};
    // Frame limits by option
    wire [CNT_W-1:0] tx_lim = ctrl[C_PERF] ? FRAME_MAX_PERF_TX : FRAME_MAX_NORM;
    wire [CNT_W-1:0] rx_lim = ctrl[C_PERF] ? FRAME_MAX_PERF_RX : FRAME_MAX_NORM;
    // TX FIFO feed; a full FIFO holds off the bus acknowledge
    logic       fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [7:0] fifo_out_data;
    wire tx_wr     = req && wb_we_i && hit_tx && wb_sel_i[0];
    wire tx_over   = (tx_cnt >= tx_lim);
    wire tx_stall  = tx_wr && !tx_over && !fifo_in_ready;
    wire fifo_push = tx_wr && !tx_over && fifo_in_ready;
    wire take      = req && !tx_stall;
    wire wr        = take && wb_we_i;
    wire rx_pop    = take && !wb_we_i && hit_rx;
    spm_fifo #(
        .W (DATA_BITS),
        .D (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (fifo_push),
        .in_data_i   (wb_dat_i[7:0]),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (fifo_out_valid),
        .out_data_o  (fifo_out_data),
        .out_ready_i (fifo_pop)
    );
    // Transmitter state and send permission
    spm_state_t       tx_st;
    logic [DIV_W-1:0] tx_tmr;
    logic [2:0]       tx_bit;
    logic [7:0]       tx_sh;
    logic             tx_par, tx_stop2;
    wire tx_idle   = (tx_st == ST_IDLE);
    wire tx_tick   = (tx_tmr == '0);
    wire may_send  = rts_o && (cts_f || !ctrl[C_FLOW]);
    assign fifo_pop = tx_idle && fifo_out_valid && may_send;
    wire next_rts  = (ctrl[C_READY] && fifo_out_valid) || !tx_idle;
    wire tx_drain  = tx_idle && !fifo_out_valid && !fifo_push;
    // Character framing on the transmit side
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_st    <= ST_IDLE;
            tx_tmr   <= '0;
            tx_bit   <= '0;
            tx_sh    <= '0;
            tx_par   <= 1'b0;
            tx_stop2 <= 1'b0;
            txd_o    <= 1'b1;
        end else begin
            tx_tmr <= tx_tick ? div_top : tx_tmr - 1'b1;
            unique case (tx_st)
                ST_IDLE: begin
                    txd_o <= 1'b1;
                    if (fifo_pop) begin
                        tx_st  <= ST_START;
                        tx_sh  <= fifo_out_data;
                        tx_par <= ctrl[C_PAR_ODD] ^ (^fifo_out_data);
                        tx_tmr <= div_top;
                        txd_o  <= 1'b0;
                    end
                end
                ST_START: if (tx_tick) begin
                    tx_st  <= ST_DATA;
                    tx_bit <= '0;
                    txd_o  <= tx_sh[0];
                end
                ST_DATA: if (tx_tick) begin
                    tx_bit <= tx_bit + 1'b1;
                    tx_sh  <= {1'b0, tx_sh[7:1]};
                    if (tx_bit == 3'(DATA_BITS - 1)) begin
                        tx_st    <= ctrl[C_PAR_EN] ? ST_PAR : ST_STOP;
                        txd_o    <= ctrl[C_PAR_EN] ? tx_par : 1'b1;
                        tx_stop2 <= ctrl[C_TWO_STOP];
                    end else begin
                        txd_o <= tx_sh[1];
                    end
                end
                ST_PAR: if (tx_tick) begin
                    tx_st <= ST_STOP;
                    txd_o <= 1'b1;
                end
                ST_STOP: if (tx_tick) begin
                    tx_stop2 <= 1'b0;
                    if (!tx_stop2) tx_st <= ST_IDLE;
                end
            endcase
        end
    end
    // Receiver state, bit timer and idle-gap counter
    spm_state_t       rx_st;
    logic [DIV_W-1:0] rx_tmr;
    logic [2:0]       rx_bit;
    logic [7:0]       rx_sh;
    logic             rx_par_bad;
    logic [DIV_W-1:0] gap_tmr;
    logic [5:0]       gap_cnt;
    wire rx_tick  = (rx_tmr == '0);
    wire rx_done  = (rx_st == ST_STOP) && rx_tick;
    wire rx_keep  = rx_done && rx_f && (rx_cnt < rx_lim);
    wire rx_limit = rx_done && rx_f && (rx_cnt >= rx_lim);
    wire gap_end  = (rx_st == ST_IDLE) && rx_f && (gap_cnt == gap_bits)
                    && (rx_cnt != '0);
    // Character framing on the receive side, sampled mid-bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_st      <= ST_IDLE;
            rx_tmr     <= '0;
            rx_bit     <= '0;
            rx_sh      <= '0;
            rx_par_bad <= 1'b0;
        end else begin
            rx_tmr <= rx_tick ? div_top : rx_tmr - 1'b1;
            unique case (rx_st)
                ST_IDLE: if (!rx_f) begin
                    rx_st  <= ST_START;
                    rx_tmr <= div_half;
                end
                ST_START: if (rx_tick) begin
                    rx_st  <= rx_f ? ST_IDLE : ST_DATA;
                    rx_bit <= '0;
                end
                ST_DATA: if (rx_tick) begin
                    rx_sh  <= {rx_f, rx_sh[7:1]};
                    rx_bit <= rx_bit + 1'b1;
                    if (rx_bit == 3'(DATA_BITS - 1))
                        rx_st <= ctrl[C_PAR_EN] ? ST_PAR : ST_STOP;
                end
                ST_PAR: if (rx_tick) begin
                    rx_par_bad <= (^rx_sh) ^ rx_f ^ ctrl[C_PAR_ODD];
                    rx_st      <= ST_STOP;
                end
                ST_STOP: if (rx_tick) begin
                    rx_st <= ST_IDLE;
                end
            endcase
        end
    end
    // Idle-gap timer closing a received frame
    always_ff @(posedge clk_i) begin
        if (rst_i || rx_st != ST_IDLE || !rx_f) begin
            gap_tmr <= '0;
            gap_cnt <= '0;
        end else if (gap_tmr == div_top) begin
            gap_tmr <= '0;
            if (gap_cnt != gap_bits) gap_cnt <= gap_cnt + 1'b1;
        end else begin
            gap_tmr <= gap_tmr + 1'b1;
        end
    end
    // Received byte holding register and frame counters
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_byte  <= '0;
            rx_valid <= 1'b0;
            rx_cnt   <= '0;
            tx_cnt   <= '0;
        end else begin
            if (rx_keep) begin
                rx_byte  <= rx_sh;
                rx_valid <= 1'b1;
            end else if (rx_pop) begin
                rx_valid <= 1'b0;
            end
            if (gap_end) rx_cnt <= '0;
            else if (rx_keep) rx_cnt <= rx_cnt + 1'b1;
            if (tx_drain) tx_cnt <= '0;
            else if (fifo_push) tx_cnt <= tx_cnt + 1'b1;
        end
    end
    // Sticky flag set terms; set wins over clear
    logic [FLAG_W-1:0] flag_set;
    always_comb begin
        flag_set              = '0;
        flag_set[S_FRAME_ERR] = rx_done && !rx_f;
        flag_set[S_PAR_ERR]   = rx_done && ctrl[C_PAR_EN] && rx_par_bad;
        flag_set[S_OVERRUN]   = rx_keep && rx_valid && !rx_pop;
        flag_set[S_TX_LIMIT]  = tx_wr && tx_over;
        flag_set[S_RX_LIMIT]  = rx_limit;
        flag_set[S_RX_END]    = gap_end;
    end
    wire [FLAG_W-1:0] flag_clr = (wr && hit_stat && wb_sel_i[1]) ?
                                 wb_dat_i[8 +: FLAG_W] : '0;
    // Sticky flag register
    always_ff @(posedge clk_i) begin
        if (rst_i) flags <= '0;
        else       flags <= (flags & ~flag_clr) | flag_set;
    end
    // Configuration writes honour byte lanes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= CTRL_RESET;
            baud <= DIV_RESET;
        end else if (wr) begin
            if (hit_ctrl && wb_sel_i[0]) ctrl[7:0]    <= wb_dat_i[7:0];
            if (hit_ctrl && wb_sel_i[1]) ctrl[C_FLOW] <= wb_dat_i[C_FLOW];
            if (hit_baud && wb_sel_i[0]) baud[7:0]    <= wb_dat_i[7:0];
            if (hit_baud && wb_sel_i[1]) baud[15:8]   <= wb_dat_i[15:8];
            if (hit_baud && wb_sel_i[2]) baud[19:16]  <= wb_dat_i[19:16];
        end
    end
    // Read data selection
    wire [31:0] rd_stat  = {18'h0, flags, pin_f[4:1], !tx_idle, rx_valid,
                            !fifo_in_ready, !fifo_out_valid};
    wire [31:0] rd_frame = {4'h0, rx_cnt, 4'h0, tx_cnt};
    wire [31:0] rd_data  = hit_ctrl ? {23'h0, ctrl} :
                           hit_baud ? {12'h0, div_eff} :
                           hit_rx   ? {23'h0, rx_valid, rx_byte} :
                           hit_stat ? rd_stat :
                           hit_frm  ? rd_frame : 32'h0;
    // One-cycle answer; unmapped offsets read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= take;
            wb_dat_o <= (take && !wb_we_i) ? rd_data : 32'h0;
        end
    end
    // Modem and link outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rts_o      <= 1'b0;
            dtr_o      <= 1'b0;
            link_485_o <= 1'b0;
            drv_en_o   <= 1'b0;
        end else begin
            rts_o      <= next_rts;
            dtr_o      <= ctrl[C_READY];
            link_485_o <= link485;
            drv_en_o   <= link485 && next_rts;
        end
    end
endmodule : spm_serial_port

// [sim/spm_port_monitor.sv]
// Checker for the serial port: bus answer, modem outputs, transmit line.
// Bound to spm_serial_port; sees its ports only, one clock domain.
`timescale 1ns/1ps

module spm_port_monitor
    import spm_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic        txd_o,
    input  wire logic        rts_o,
    input  wire logic        dtr_o,
    input  wire logic        link_485_o,
    input  wire logic        drv_en_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Decoded bus events in the ack cycle
    wire logic        acc_ack = wb_cyc_i && wb_stb_i && wb_ack_o;
    wire logic        ctrl_wr = acc_ack && wb_we_i && wb_adr_i == ADDR_CTRL && wb_sel_i[0];
    wire logic        baud_rd = acc_ack && !wb_we_i && wb_adr_i == ADDR_BAUD;
    wire logic [19:0] baud_q  = wb_dat_o[19:0];
    wire logic        rdy_wd  = wb_dat_i[C_READY];
    wire logic        link_wd = wb_dat_i[C_LINK485];

    // Transmit line and handshake
    chk_txd_idle_high: assert property (!rts_o |-> txd_o)
        else $error("txd low while rts low");
    chk_start_needs_rts: assert property ($fell(txd_o) |-> rts_o && $past(rts_o))
        else $error("start bit without rts");
    chk_rts_needs_dtr: assert property ($rose(rts_o) |-> dtr_o)
        else $error("rts rose while not ready");
    chk_start_bit_low: assert property ($fell(txd_o) |=> !txd_o [*8])
        else $error("start bit too short");
    chk_stop_before_start: assert property ($fell(txd_o) |-> $past(txd_o, 8))
        else $error("start bit without stop level before");
    // Modem outputs follow the control register
    chk_dtr_follows_ctrl: assert property (ctrl_wr |=> dtr_o == $past(rdy_wd))
        else $error("dtr not following ready bit");
    chk_link_follows_ctrl: assert property (ctrl_wr |=> link_485_o == $past(link_wd))
        else $error("link select not following");
    chk_drv_en_link: assert property (drv_en_o |-> rts_o && link_485_o)
        else $error("driver enable outside 485 send");
    // Bit rate clamping and one-cycle acknowledge
    chk_baud_range: assert property (baud_rd |-> baud_q >= DIV_MIN_485 && baud_q <= DIV_MAX)
        else $error("bit period out of range");
    chk_baud_232_max: assert property (baud_rd && !link_485_o |-> baud_q >= DIV_MIN_232)
        else $error("rs232 rate above limit");
    chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    cover property ($fell(txd_o));
    cover property (baud_rd && link_485_o);
    cover property ($rose(drv_en_o));
endmodule : spm_port_monitor

// [sim/spm_line_partner.sv]
// Line partner model: remote station with modem lines on the serial link.
// Assumes 8 data bits, no parity, one stop bit, BIT_CYC clocks per bit.
`timescale 1ns/1ps

module spm_line_partner #(
    parameter int BIT_CYC = 800
) (
    input  wire logic clk_i,
    input  wire logic txd_i,
    output logic      rxd_o,
    output logic      cts_o,
    output logic      dsr_o,
    output logic      dcd_o,
    output logic      ri_o
);
    logic [8:0] rx_q [$];
    logic [8:0] got;

    // Idle line high, modem lines off
    initial begin
        rxd_o = 1'b1;
        {ri_o, dcd_o, dsr_o, cts_o} = 4'h0;
    end

    // Set ring, carrier, set-ready and clear-to-send together
    task automatic set_lines(input logic [3:0] v);
        {ri_o, dcd_o, dsr_o, cts_o} <= v;
    endtask : set_lines

    // One character, carrier raised while it runs
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        dcd_o <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rxd_o <= f[i];
            repeat (BIT_CYC) @(posedge clk_i);
        end
        dcd_o <= 1'b0;
    endtask : send_byte

    // Sample sent characters mid-bit; stop level kept above data
    initial begin
        forever begin
            @(posedge clk_i);
            if (txd_i === 1'b0) begin
                repeat (BIT_CYC / 2) @(posedge clk_i);
                for (int i = 0; i < 9; i++) begin
                    repeat (BIT_CYC) @(posedge clk_i);
                    got[i] = txd_i;
                end
                rx_q.push_back(got);
            end
        end
    end
endmodule : spm_line_partner

// [sim/tb_top.sv]
// Bench for the serial port: registers over Wishbone, line traffic.
// Assumes the partner model and monitor are compiled before it.
`timescale 1ns/1ps

module tb_top;
    import spm_pkg::*;
    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        rxd, cts, dsr, dcd, ri;
    logic        txd_o, rts_o, dtr_o, link_485_o, drv_en_o;
    logic [31:0] q;
    int          fail_count = 0;
    int          total_checks = 0;
    logic [7:0]  tx_b [7] = '{8'h3c, 8'ha5, 8'h01, 8'h80, 8'h5a, 8'hff, 8'h00};

    spm_serial_port u_spm_serial_port (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd_i(rxd), .cts_i(cts), .dsr_i(dsr),
        .dcd_i(dcd), .ri_i(ri), .txd_o(txd_o), .rts_o(rts_o), .dtr_o(dtr_o),
        .link_485_o(link_485_o), .drv_en_o(drv_en_o));
    spm_line_partner #(.BIT_CYC(int'(DIV_MIN_485))) u_spm_line_partner (
        .clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd), .cts_o(cts), .dsr_o(dsr),
        .dcd_o(dcd), .ri_o(ri));

    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever begin
            #2.5 clk_i = ~clk_i;
        end
    end

    // Classic single cycle, held until ack is sampled
    task automatic wb_acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20000);
        q = wb_dat_o;
        if (wb_ack_o !== 1'b1) begin
            fail_count++;
            $display("Error ack expected 1 seen %b", wb_ack_o);
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb_acc

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string nm);
        wb_acc(1'b0, a, 32'h0);
        chk(nm, e, q & m);
    endtask : rdc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_acc(1'b1, a, d);
    endtask : wr

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        int n;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("txd", 32'h1, {31'h0, txd_o});
        chk("rts", 32'h0, {31'h0, rts_o});
        chk("dtr", 32'h0, {31'h0, dtr_o});
        rdc(ADDR_BAUD, 32'hfffff, 32'(DIV_RESET), "baud reset");
        $display("Test reset done");
        wr(ADDR_BAUD, 32'h1);
        rdc(ADDR_BAUD, 32'hfffff, 32'(DIV_MIN_232), "baud 232");
        wr(ADDR_BAUD, 32'hfffff);
        rdc(ADDR_BAUD, 32'hfffff, 32'(DIV_MAX), "baud max");
        wr(ADDR_CTRL, 32'h2);
        wr(ADDR_BAUD, 32'h1);
        rdc(ADDR_BAUD, 32'hfffff, 32'(DIV_MIN_485), "baud 485");
        chk("link", 32'h1, {31'h0, link_485_o});
        for (int p = 0; p < 4; p++) begin
            wr(ADDR_CTRL, (32'(p) << C_PROTO_LO) | 32'h2);
            rdc(ADDR_CTRL, 32'h1ff, (32'(p) << C_PROTO_LO) | 32'h2, "proto");
        end
        $display("Test config done");
        for (int i = 0; i < 4; i++) begin
            u_spm_line_partner.set_lines(4'(1 << i));
            repeat (8) @(posedge clk_i);
            rdc(ADDR_STATUS, 32'hf0, 32'h10 << i, "modem in");
        end
        u_spm_line_partner.set_lines(4'h0);
        wr(ADDR_CTRL, 32'h2);
        rdc(8'h18, 32'hffffffff, 32'h0, "unmapped");
        wr(8'h18, 32'hffffffff);
        rdc(ADDR_CTRL, 32'h1ff, 32'h2, "ctrl kept");
        wr(ADDR_TXDATA, {24'h0, tx_b[0]});
        repeat (50) @(posedge clk_i);
        chk("rts held", 32'h0, {31'h0, rts_o});
        chk("txd held", 32'h1, {31'h0, txd_o});
        rdc(ADDR_STATUS, 32'h1, 32'h0, "tx queued");
        $display("Test hold done");
        wr(ADDR_CTRL, 32'h3);
        chk("dtr on", 32'h1, {31'h0, dtr_o});
        for (int i = 1; i < 7; i++) begin
            wr(ADDR_TXDATA, {24'h0, tx_b[i]});
        end
        chk("drv en", 32'h1, {31'h0, drv_en_o});
        n = 0;
        while (u_spm_line_partner.rx_q.size() < 7 && n < 70000) begin
            @(posedge clk_i);
            n++;
        end
        for (int i = 0; i < 7; i++) begin
            chk("tx char", {23'h1, tx_b[i]}, 32'(u_spm_line_partner.rx_q[i]));
        end
        repeat (1000) @(posedge clk_i);
        rdc(ADDR_STATUS, 32'h9, 32'h1, "tx drained");
        chk("rts off", 32'h0, {31'h0, rts_o});
        $display("Test transmit done");
        u_spm_line_partner.send_byte(8'h96);
        repeat (20) @(posedge clk_i);
        rdc(ADDR_RXDATA, 32'h1ff, 32'h196, "rx char");
        rdc(ADDR_RXDATA, 32'h100, 32'h0, "rx popped");
        $display("Test receive done");
        wr(ADDR_CTRL, 32'h103);
        wr(ADDR_TXDATA, 32'h69);
        repeat (50) @(posedge clk_i);
        chk("cts hold", 32'h1, {31'h0, txd_o});
        chk("rts wait", 32'h1, {31'h0, rts_o});
        u_spm_line_partner.set_lines(4'h1);
        repeat (8500) @(posedge clk_i);
        chk("cts char", 32'h169, 32'(u_spm_line_partner.rx_q[7]));
        $display("Test flow done");
        finish_test();
    end

    // Watchdog; the run needs about 75000 cycles
    initial begin
        repeat (90000) @(posedge clk_i);
        fail_count++;
        $display("Error watchdog expected done seen running");
        finish_test();
    end
endmodule : tb_top

bind spm_serial_port spm_port_monitor u_spm_port_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txd_o(txd_o), .rts_o(rts_o),
    .dtr_o(dtr_o), .link_485_o(link_485_o), .drv_en_o(drv_en_o));
